// ---- ssti_consts.svh ----
// Purpose: constants for the scan-port instruction logic of the static RAM
// Assumes: included by bare name wherever a figure is needed
// Notes:   instruction codes are written msb first; bit 0 is shifted first
`ifndef SSTI_CONSTS_SVH
`define SSTI_CONSTS_SVH

`define SSTI_IR_W        3
`define SSTI_TAP_W       4
`define SSTI_SYNC_W      2
`define SSTI_IR_ZEROS    3'h0
`define SSTI_IR_IDCODE   3'h1
`define SSTI_IR_SAMPLEZ  3'h2
`define SSTI_IR_RSV_A    3'h3
`define SSTI_IR_SAMPLE   3'h4
`define SSTI_IR_RSV_B    3'h5
`define SSTI_IR_RSV_C    3'h6
`define SSTI_IR_BYPASS   3'h7
`define SSTI_IR_CAPTURE  3'h1
`define SSTI_ID_W        32
// identity value is arbitrary; bit 0 set as scan convention requires
`define SSTI_ID_VALUE    32'h0a5c_3e01
`define SSTI_BSR_LEN     51
`define SSTI_BYPASS_CAP  1'b0

`endif

// ---- ssti_pkg.sv ----
// Purpose: shared types of the scan-port instruction logic
// Assumes: ssti_consts.svh gives every width
// Notes:   state codes follow the usual controller numbering of this team
`include "ssti_consts.svh"
package ssti_pkg;
  typedef enum logic [`SSTI_TAP_W-1:0] {
    TAP_RESET   = 4'h0,
    TAP_IDLE    = 4'h1,
    TAP_SEL_DR  = 4'h2,
    TAP_CAP_DR  = 4'h3,
    TAP_SH_DR   = 4'h4,
    TAP_EX1_DR  = 4'h5,
    TAP_PA_DR   = 4'h6,
    TAP_EX2_DR  = 4'h7,
    TAP_UP_DR   = 4'h8,
    TAP_SEL_IR  = 4'h9,
    TAP_CAP_IR  = 4'ha,
    TAP_SH_IR   = 4'hb,
    TAP_EX1_IR  = 4'hc,
    TAP_PA_IR   = 4'hd,
    TAP_EX2_IR  = 4'he,
    TAP_UP_IR   = 4'hf
  } ssti_state_e;

  typedef logic [`SSTI_IR_W-1:0] ssti_ir_t;
endpackage : ssti_pkg

// ---- ssti_tap_if.sv ----
// Purpose: carries test-clock edge, mode select and controller state
// Assumes: all signals live in the system clock domain
// Notes:   tck_rise is a one-cycle pulse
`timescale 1ns/1ps
`default_nettype none
interface ssti_tap_if;
  logic                  tck_rise;
  logic                  tms;
  ssti_pkg::ssti_state_e state;
  modport fsm  (input tck_rise, input tms, output state);
  modport user (output tck_rise, output tms, input state);
endinterface : ssti_tap_if
`default_nettype wire

// ---- ssti_tap_fsm.sv ----
// Purpose: tracks the sixteen test-access controller states
// Assumes: tck_rise marks a synchronised rising test clock edge
// Notes:   reset parks the controller in test-logic-reset
`timescale 1ns/1ps
`default_nettype none
module ssti_tap_fsm (
  input  wire logic clock,
  input  wire logic rst,
  ssti_tap_if.fsm   tap
);
  import ssti_pkg::*;

  ssti_state_e state;
  ssti_state_e next_state;
  logic        m;

  assign m         = tap.tms;
  assign tap.state = state;

  always_comb begin
    case (state)
      TAP_RESET:  next_state = m ? TAP_RESET  : TAP_IDLE;
      TAP_IDLE:   next_state = m ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_DR: next_state = m ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR: next_state = m ? TAP_EX1_DR : TAP_SH_DR;
      TAP_SH_DR:  next_state = m ? TAP_EX1_DR : TAP_SH_DR;
      TAP_EX1_DR: next_state = m ? TAP_UP_DR  : TAP_PA_DR;
      TAP_PA_DR:  next_state = m ? TAP_EX2_DR : TAP_PA_DR;
      TAP_EX2_DR: next_state = m ? TAP_UP_DR  : TAP_SH_DR;
      TAP_UP_DR:  next_state = m ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_IR: next_state = m ? TAP_RESET  : TAP_CAP_IR;
      TAP_CAP_IR: next_state = m ? TAP_EX1_IR : TAP_SH_IR;
      TAP_SH_IR:  next_state = m ? TAP_EX1_IR : TAP_SH_IR;
      TAP_EX1_IR: next_state = m ? TAP_UP_IR  : TAP_PA_IR;
      TAP_PA_IR:  next_state = m ? TAP_EX2_IR : TAP_PA_IR;
      TAP_EX2_IR: next_state = m ? TAP_UP_IR  : TAP_SH_IR;
      TAP_UP_IR:  next_state = m ? TAP_SEL_DR : TAP_IDLE;
      default:    next_state = TAP_RESET;
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state <= TAP_RESET;
    end else if (tap.tck_rise) begin
      state <= next_state;
    end
  end
endmodule : ssti_tap_fsm
`default_nettype wire

// ---- ssti_top.sv ----
// Purpose: instruction and data register logic of the RAM scan port
// Assumes: test clock sampled by the 50 MHz system clock, far slower
// Notes:   observe only; nothing here can reach the memory array
//
// Overview of operation
// - capture-IR loads 01 into low bits
// - shift-IR puts instruction register on serial path
// - new instruction takes effect only at update-IR
// - code 111 selects bypass, RAM untouched
// - code 100 captures pad states at capture-DR
// - sampling codes shift boundary register in shift-DR
// - update-DR under sampling acts like pause-DR
// - code 000 samples and holds data pins high-Z
// - code 001 captures and shifts identity register
// - identity code active at reset and test-logic-reset
// - code 010 floats data pins, samples, shifts boundary
// - port only observes; never drives memory or buffers
// - identity, bypass, sampling leave RAM untouched
// - codes written msb first, lsb shifted first
`timescale 1ns/1ps
`default_nettype none
`include "ssti_consts.svh"
module ssti_top #(
  parameter int                     BSR_LEN  = `SSTI_BSR_LEN,
  parameter logic [`SSTI_ID_W-1:0]  ID_VALUE = `SSTI_ID_VALUE
) (
  input  wire logic               clock,
  input  wire logic               rst,
  input  wire logic               tck,
  input  wire logic               tms,
  input  wire logic               tdi,
  input  wire logic [BSR_LEN-1:0] pad_state,
  output logic                    tdo,
  output logic                    tdo_oe,
  output logic                    dq_hiz,
  output ssti_pkg::ssti_ir_t      active_ir
);
  import ssti_pkg::*;

  // two-flop synchronisers; a third tck stage only feeds edge detection
  logic [`SSTI_SYNC_W-1:0] tck_sync;
  logic [`SSTI_SYNC_W-1:0] tms_sync;
  logic [`SSTI_SYNC_W-1:0] tdi_sync;
  logic                    tck_last;
  logic [BSR_LEN-1:0]      pad_meta;
  logic [BSR_LEN-1:0]      pad_s;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      tck_sync <= '0;
      tms_sync <= '1;
      tdi_sync <= '1;
      tck_last <= 1'b0;
      pad_meta <= '0;
      pad_s    <= '0;
    end else begin
      tck_sync <= {tck_sync[0], tck};
      tms_sync <= {tms_sync[0], tms};
      tdi_sync <= {tdi_sync[0], tdi};
      tck_last <= tck_sync[1];
      pad_meta <= pad_state;
      pad_s    <= pad_meta;
    end
  end

  wire tck_s    = tck_sync[1];
  wire tdi_s    = tdi_sync[1];
  wire tck_rise = tck_s & ~tck_last;
  wire tck_fall = ~tck_s & tck_last;

  ssti_tap_if tap ();
  assign tap.tck_rise = tck_rise;
  assign tap.tms      = tms_sync[1];

  ssti_tap_fsm u_fsm (
    .clock (clock),
    .rst   (rst),
    .tap   (tap)
  );

  ssti_state_e state;
  assign state = tap.state;

  // decode of the current controller state and instruction
  wire in_cap_ir = tck_rise && state == TAP_CAP_IR;
  wire in_sh_ir  = tck_rise && state == TAP_SH_IR;
  wire in_cap_dr = tck_rise && state == TAP_CAP_DR;
  wire in_sh_dr  = tck_rise && state == TAP_SH_DR;
  wire in_up_ir  = tck_fall && state == TAP_UP_IR;
  wire shifting  = state == TAP_SH_IR || state == TAP_SH_DR;

  // reserved codes fall back to bypass so that the chain stays one stage long
  wire sel_bsr   = active_ir == `SSTI_IR_ZEROS || active_ir == `SSTI_IR_SAMPLE ||
                   active_ir == `SSTI_IR_SAMPLEZ;
  wire sel_id    = active_ir == `SSTI_IR_IDCODE;
  wire sel_byp   = !sel_bsr && !sel_id;
  wire next_hiz  = active_ir == `SSTI_IR_ZEROS || active_ir == `SSTI_IR_SAMPLEZ;

  ssti_ir_t              ir_shift;
  logic                  bypass;
  logic [`SSTI_ID_W-1:0] id_shift;
  logic [BSR_LEN-1:0]    bsr;

  // instruction register shift stage, lsb leaves first
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ir_shift <= `SSTI_IR_CAPTURE;
    end else if (in_cap_ir) begin
      ir_shift <= `SSTI_IR_CAPTURE;
    end else if (in_sh_ir) begin
      ir_shift <= {tdi_s, ir_shift[`SSTI_IR_W-1:1]};
    end
  end

  // active instruction only moves at update-IR or controller reset
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      active_ir <= `SSTI_IR_IDCODE;
    end else if (state == TAP_RESET) begin
      active_ir <= `SSTI_IR_IDCODE;
    end else if (in_up_ir) begin
      active_ir <= ir_shift;
    end
  end

  // data registers; update-DR is ignored on purpose, nothing is preloaded
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      bypass   <= `SSTI_BYPASS_CAP;
      id_shift <= '0;
      bsr      <= '0;
    end else if (in_cap_dr) begin
      bypass   <= `SSTI_BYPASS_CAP;
      if (sel_id) id_shift <= ID_VALUE;
      if (sel_bsr) bsr <= pad_s;
    end else if (in_sh_dr) begin
      if (sel_byp) bypass <= tdi_s;
      if (sel_id) id_shift <= {tdi_s, id_shift[`SSTI_ID_W-1:1]};
      if (sel_bsr) bsr <= {tdi_s, bsr[BSR_LEN-1:1]};
    end
  end

  wire dr_out = sel_bsr ? bsr[0] : (sel_id ? id_shift[0] : bypass);
  wire next_tdo = state == TAP_SH_IR ? ir_shift[0] : dr_out;

  // serial output moves on the falling edge so the far end samples on the rise
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      tdo    <= 1'b0;
      tdo_oe <= 1'b0;
    end else if (tck_fall) begin
      tdo    <= next_tdo;
      tdo_oe <= shifting;
    end
  end

  // only the data pins float; the memory path itself is never driven here
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      dq_hiz <= 1'b0;
    end else begin
      dq_hiz <= next_hiz;
    end
  end

  // all checks run on the system clock and rest while reset is high
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  chk_ir_capture_value: assert property (
      in_cap_ir |=> ir_shift == `SSTI_IR_CAPTURE)
    else $error("capture-IR did not load 01");
  chk_ir_shift_path: assert property (
      in_sh_ir |=> ir_shift[`SSTI_IR_W-1] == $past(tdi_s))
    else $error("instruction shift lost serial input");
  chk_ir_hold_active: assert property (
      !in_up_ir && state != TAP_RESET |=> $stable(active_ir))
    else $error("active instruction moved outside update-IR");
  chk_bypass_delay: assert property (
      in_sh_dr && sel_byp |=> bypass == $past(tdi_s))
    else $error("bypass stage did not delay serial input");
  chk_bsr_capture: assert property (
      in_cap_dr && sel_bsr |=> bsr == $past(pad_s))
    else $error("boundary register missed pad capture");
  chk_update_dr_quiet: assert property (
      tck_fall && state == TAP_UP_DR |=> $stable(bsr) && $stable(dq_hiz))
    else $error("update-DR changed boundary state");
  chk_zeros_hiz_hold: assert property (
      (active_ir == `SSTI_IR_ZEROS) [*2] |-> dq_hiz)
    else $error("all-zeros code let data pins drive");
  chk_id_capture: assert property (
      in_cap_dr && sel_id |=> id_shift == ID_VALUE)
    else $error("identity value not captured");
  chk_tlr_idcode: assert property (
      state == TAP_RESET |=> active_ir == `SSTI_IR_IDCODE)
    else $error("test-logic-reset did not select identity");
  chk_quiet_no_hiz: assert property (
      (sel_id || sel_byp || active_ir == `SSTI_IR_SAMPLE) [*2] |-> !dq_hiz)
    else $error("non-floating code floated data pins");
  chk_tdo_enable: assert property (
      tck_fall |=> tdo_oe == $past(shifting))
    else $error("serial output enable outside shift states");

  // shift paths, fixed captures, the floating sample code and the promise that nothing is preloaded
  chk_bsr_shift_path: assert property (
      in_sh_dr && sel_bsr |=> bsr[BSR_LEN-1] == $past(tdi_s))
    else $error("boundary shift lost serial input");
  chk_id_shift_path: assert property (
      in_sh_dr && sel_id |=> id_shift[`SSTI_ID_W-1] == $past(tdi_s))
    else $error("identity shift lost serial input");
  chk_bypass_capture: assert property (
      in_cap_dr |=> bypass == `SSTI_BYPASS_CAP)
    else $error("bypass stage did not capture zero");
  chk_samplez_hiz: assert property (
      (active_ir == `SSTI_IR_SAMPLEZ) [*2] |-> dq_hiz)
    else $error("floating sample code let data pins drive");
  chk_bsr_no_preload: assert property (
      !in_cap_dr && !in_sh_dr |=> $stable(bsr))
    else $error("boundary register changed outside capture and shift");
  chk_ir_lsb_out: assert property (
      tck_fall && state == TAP_SH_IR |=> tdo == $past(ir_shift[0]))
    else $error("instruction lsb not presented first");
  chk_bypass_out: assert property (
      tck_fall && state == TAP_SH_DR && sel_byp |=> tdo == $past(bypass))
    else $error("bypass stage not on serial output");

  // main scenarios the bench should reach
  cov_update_ir: cover property (in_up_ir);
  cov_sample_shift: cover property (in_sh_dr && active_ir == `SSTI_IR_SAMPLE);
  cov_samplez_hiz: cover property (active_ir == `SSTI_IR_SAMPLEZ ##1 dq_hiz);
  cov_bypass_shift: cover property (in_sh_dr && active_ir == `SSTI_IR_BYPASS);
  cov_id_shift: cover property (in_sh_dr && sel_id);
endmodule : ssti_top
`default_nettype wire

// ---- ssti_ctl_model.sv ----
// Purpose: behavioural scan controller driving the test port pins
// Assumes: test clock half period 80 ns; it stands low between frames
// Notes:   serial output is read through its enable, as the board wire would show it
`timescale 1ns/1ps
`default_nettype none
module ssti_ctl_model (
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  input  wire logic tdo,
  input  wire logic tdo_oe
);
  logic line_level;

  // an undriven wire reads as z, so a missing enable cannot pass for data
  assign line_level = tdo_oe ? tdo : 1'bz;

  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end

  // mode and data move only while the clock is low; output taken 40 ns after the rise
  task automatic step(input logic m, input logic d, output logic seen);
    tms = m;
    tdi = d;
    #80 tck = 1'b1;
    #40 seen = line_level;
    #40 tck = 1'b0;
  endtask : step
endmodule : ssti_ctl_model
`default_nettype wire

// ---- ssti_top_tb.sv ----
// Purpose: self-checking bench for the scan-port instruction logic
// Assumes: a shortened boundary register of 8 stages
// Notes:   pads change only while the test clock stands still
`timescale 1ns/1ps
`default_nettype none
`include "ssti_consts.svh"
module ssti_top_tb;
  import ssti_pkg::*;
  localparam int          BSR   = 8;
  localparam logic [31:0] TB_ID = 32'h5a0f_c3a5; // arbitrary identity, bit 0 set
  localparam logic [7:0]  PAT   = 8'h6d;
  typedef struct packed {
    ssti_ir_t   code;
    logic       hiz;
    logic [1:0] kind;
  } ssti_row_s;
  logic           clock;
  logic           rst;
  logic           tck;
  logic           tms;
  logic           tdi;
  logic [BSR-1:0] pad_state;
  logic           tdo;
  logic           tdo_oe;
  logic           dq_hiz;
  ssti_ir_t       active_ir;
  logic           s;
  ssti_row_s      rows [5];
  int             n_errors;
  int             checks_done;

  ssti_top #(.BSR_LEN(BSR), .ID_VALUE(TB_ID)) DUT (
    .clock(clock), .rst(rst), .tck(tck), .tms(tms), .tdi(tdi), .pad_state(pad_state),
    .tdo(tdo), .tdo_oe(tdo_oe), .dq_hiz(dq_hiz), .active_ir(active_ir));
  ssti_ctl_model ctl (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe));

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : close_out

  task automatic go(input logic m, input logic d);
    ctl.step(m, d, s);
  endtask : go

  // from idle: capture 001, shift code lsb first, update, back to idle
  task automatic load_ir(input ssti_ir_t code);
    ssti_ir_t   prev;
    logic [2:0] got;
    prev = active_ir;
    go(1'b1, 1'b0);
    go(1'b1, 1'b0);
    go(1'b0, 1'b0);
    go(1'b0, 1'b0);
    for (int i = 0; i < 3; i++) begin
      ctl.step(i == 2, code[i], s);
      got[i] = s;
    end
    check("ir shifted out", got, `SSTI_IR_CAPTURE);
    check("ir before update", active_ir, prev);
    go(1'b1, 1'b0);
    go(1'b0, 1'b0);
    go(1'b0, 1'b0);
    check("tdo idle", s, 1'bz);
    check("ir after update", active_ir, code);
  endtask : load_ir

  // kind 0 boundary, 1 identity, 2 bypass
  task automatic scan_dr(input int n, input logic [1:0] kind);
    logic [31:0] got;
    logic [31:0] exp;
    got = '0;
    exp = '0;
    go(1'b1, 1'b0);
    go(1'b0, 1'b0);
    go(1'b0, 1'b0);
    for (int i = 0; i < n; i++) begin
      ctl.step(i == n - 1, PAT[i % 8], s);
      got[i] = s;
      if (kind == 2'd1) exp[i] = TB_ID[i];
      else if (kind == 2'd2) exp[i] = (i == 0) ? `SSTI_BYPASS_CAP : PAT[(i - 1) % 8];
      else exp[i] = pad_state[i];
    end
    go(1'b1, 1'b0);
    go(1'b0, 1'b0);
    check("dr shifted out", got, exp);
  endtask : scan_dr

  initial begin
    rst = 1'b1;
    pad_state = '0;
    n_errors = 0;
    checks_done = 0;
    // reserved codes are never loaded
    rows[0] = {`SSTI_IR_ZEROS, 1'b1, 2'd0};
    rows[1] = {`SSTI_IR_IDCODE, 1'b0, 2'd1};
    rows[2] = {`SSTI_IR_SAMPLEZ, 1'b1, 2'd0};
    rows[3] = {`SSTI_IR_SAMPLE, 1'b0, 2'd0};
    rows[4] = {`SSTI_IR_BYPASS, 1'b0, 2'd2};
    repeat (3) @(posedge clock);
    #1 rst = 1'b0;
    check("after reset", {active_ir, dq_hiz, tdo_oe}, {`SSTI_IR_IDCODE, 2'b00});
    go(1'b0, 1'b0);
    $display("power-up test done");
    for (int r = 0; r < 5; r++) begin
      @(posedge clock);
      #1 pad_state = 8'h3c ^ 8'(r * 37);
      load_ir(rows[r].code);
      check("float", dq_hiz, rows[r].hiz);
      scan_dr(rows[r].kind == 2'd1 ? 32 : 8, rows[r].kind);
      check("after update dr", {active_ir, dq_hiz}, {rows[r].code, rows[r].hiz});
      $display("row %0d done", r);
    end
    load_ir(`SSTI_IR_SAMPLEZ);
    repeat (5) go(1'b1, 1'b0);
    go(1'b0, 1'b0);
    check("tms reset", {active_ir, dq_hiz}, {`SSTI_IR_IDCODE, 1'b0});
    $display("tms reset test done");
    load_ir(`SSTI_IR_ZEROS);
    go(1'b1, 1'b0);
    go(1'b0, 1'b0);
    go(1'b0, 1'b0);
    go(1'b0, 1'b1);
    @(posedge clock);
    #1 rst = 1'b1;
    #5 check("async reset", {active_ir, dq_hiz, tdo_oe}, {`SSTI_IR_IDCODE, 2'b00});
    repeat (3) @(posedge clock);
    #1 rst = 1'b0;
    go(1'b0, 1'b0);
    scan_dr(32, 2'd1);
    $display("mid-shift reset test done");
    close_out();
  end

  initial begin
    #200000;
    n_errors++;
    $display("[ERR] watchdog expected finish seen hang");
    close_out();
  end
endmodule : ssti_top_tb
`default_nettype wire
